// ==== sbs_regs.svh ====
/*
 * constants of the burst sram core: array geometry, lane layout, timing.
 * assumes inclusion by bare name from the package and the core files.
 */
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

`define SBS_ADDR_W 15
`define SBS_DATA_W 32
`define SBS_WORDS 32768
`define SBS_LANES 4
`define SBS_LANE_W 8
`define SBS_CLK_MHZ 10
`define SBS_WAKE_NS 30
`define SBS_WAKE_CYC ((((`SBS_WAKE_NS * `SBS_CLK_MHZ) + 999) / 1000) < 1 ? \
    1 : (((`SBS_WAKE_NS * `SBS_CLK_MHZ) + 999) / 1000))
`define SBS_CNT_ZERO 2'h0
`define SBS_CNT_ONE 2'h1

`endif

// ==== sbs_pkg.sv ====
/*
 * types shared by the burst sram core.
 * assumes sbs_regs.svh for the numeric constants.
 */
`default_nettype none
`include "sbs_regs.svh"

package sbs_pkg;
    // cycle kinds, gray coded along idle -> read -> write
    typedef enum logic [1:0] {
        SBS_IDLE = 2'b00,
        SBS_READ = 2'b01,
        SBS_WRITE = 2'b11,
        SBS_DESEL = 2'b10
    } sbs_op_t;
endpackage

`default_nettype wire

// ==== sbs_mem.sv ====
/*
 * word array with per-lane write and registered read data.
 * assumes one clock; no reset on the array contents.
 */
`default_nettype none
`include "sbs_regs.svh"

module sbs_mem #(
    parameter int AW = `SBS_ADDR_W,
    parameter int LANES = `SBS_LANES,
    parameter int LW = `SBS_LANE_W
) (
    input wire logic clk,
    input wire logic [AW-1:0] addr,
    input wire logic [LANES-1:0] we,
    input wire logic [LANES*LW-1:0] wdata,
    output logic [LANES*LW-1:0] rdata_q,
    output logic [LANES*LW-1:0] rdata_comb
);
    // one array per lane, so each array has a single writing process
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LW-1:0] mem [0:(1<<AW)-1];
        logic [LW-1:0] rd_q;

        // unwritten lanes keep their contents
        always_ff @(posedge clk) begin
            if (we[i]) begin
                mem[addr] <= wdata[i*LW +: LW];
            end
        end

        // registered read, old data on a same-word write
        always_ff @(posedge clk) begin
            rd_q <= mem[addr];
        end

        // combinational read for flow-through mode
        assign rdata_comb[i*LW +: LW] = mem[addr];
        assign rdata_q[i*LW +: LW] = rd_q;
    end
endmodule

`default_nettype wire

// ==== sbs_core.sv ====
/*
 * control logic of a 32768 x 32 synchronous burst sram.
 * assumes one free clock, inputs already synchronous to it except the
 * output enable, snooze, burst mode and flow-through select, which are synchronised here.
 */
// Contract
// [RQ1] array of 32768 words, 32 bits each
// [RQ2] sync inputs registered on rising clock edge
// [RQ3] global write all bytes, else byte writes
// [RQ4] lane enables map to data bytes
// [RQ5] any byte enable low tristates data pins
// [RQ6] selects sampled only on address load
// [RQ7] cpu strobe loads address or deselects
// [RQ8] cpu strobe always begins a read
// [RQ9] controller strobe loads, reads/writes or deselects
// [RQ10] advance low steps burst counter
// [RQ11] advance high repeats current address
// [RQ12] host holds advance high before write
// [RQ13] output drivers follow output enable
// [RQ14] snooze high forces power down
// [RQ15] mode high interleaved, low linear
// [RQ16] flow-through low gives unregistered output; the core still registers it in DQ_OUT
// [RQ17] interleaved order xors count into low bits
// [RQ18] linear order increments low bits mod four
// [RQ19] counter wraps after fourth access
// [RQ20] deselected cycle uses no address, powers down
// [RQ21] thirty ns wake-up after snooze release
// [RQ22] host keeps configuration static
// [RQ23] host raises output enable before write
// [RQ24] pipelined read data one edge later
// [RQ25] writes self-timed within the cycle
`default_nettype none
`include "sbs_regs.svh"

module sbs_core #(
    parameter int AW = `SBS_ADDR_W,
    parameter int LANES = `SBS_LANES,
    parameter int LW = `SBS_LANE_W
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [AW-1:0] ADDR,
    input wire logic [LANES*LW-1:0] DQ_IN,
    output logic [LANES*LW-1:0] DQ_OUT,
    output logic [LANES*LW-1:0] DQ_OE,
    input wire logic PRIMARY_SELECT_N,
    input wire logic EXPAND_SELECT_LOW_N,
    input wire logic EXPAND_SELECT_HIGH,
    input wire logic CPU_ADDR_STROBE_N,
    input wire logic CTRL_ADDR_STROBE_N,
    input wire logic BURST_ADVANCE_N,
    input wire logic GLOBAL_WRITE_N,
    input wire logic MASTER_BYTE_WRITE_N,
    input wire logic BYTE_LANE0_WRITE_N,
    input wire logic BYTE_LANE1_WRITE_N,
    input wire logic BYTE_LANE2_WRITE_N,
    input wire logic BYTE_LANE3_WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SNOOZE_REQ,
    input wire logic BURST_LINEAR_N,
    input wire logic FLOW_THROUGH_SEL_N,
    output logic POWER_DOWN,
    output logic READY
);
    localparam int WAKE_CYC = `SBS_WAKE_CYC;

    // input registers, captured on the rising edge
    logic [AW-1:0] addr_in_q;
    logic [LANES*LW-1:0] din_q;
    logic sel1_n_q, sel2_n_q, sel2_q;
    logic cpu_n_q, ctrl_n_q, adv_n_q, gw_n_q, mbw_n_q;
    logic [LANES-1:0] bw_n_q;
    // asynchronous pins, two flops each
    logic oe_n_m, oe_n_s, zz_m, zz_s, mode_m, mode_s, ft_m, ft_s;
    // burst state
    logic [AW-1:0] base_q;
    logic [1:0] cnt_q, cnt_d;
    logic [AW-1:0] base_d;
    sbs_pkg::sbs_op_t op_q, op_d;
    logic [1:0] low_bits;
    logic [AW-1:0] mem_addr;
    logic [LANES-1:0] lane_we, wr_sel;
    logic wr_any, zz_hold;
    logic [LANES*LW-1:0] rd_q, rd_c;
    logic [$clog2(WAKE_CYC+1)-1:0] wake_q;
    logic [LANES*LW-1:0] dout_d;
    logic drive_d;

    // address and write data sampled at the clock edge only [RQ2]
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_in_q <= '0;
            din_q <= '0;
        end else begin
            addr_in_q <= ADDR;
            din_q <= DQ_IN;
        end
    end

    // chip selects; resting deselected so reset never looks like a load
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel1_n_q <= 1'b1;
            sel2_n_q <= 1'b1;
            sel2_q <= 1'b0;
        end else begin
            sel1_n_q <= PRIMARY_SELECT_N; // [RQ2]
            sel2_n_q <= EXPAND_SELECT_LOW_N;
            sel2_q <= EXPAND_SELECT_HIGH;
        end
    end

    // burst-control strobes, idle high after reset
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cpu_n_q <= 1'b1;
            ctrl_n_q <= 1'b1;
            adv_n_q <= 1'b1;
        end else begin
            cpu_n_q <= CPU_ADDR_STROBE_N; // [RQ2]
            ctrl_n_q <= CTRL_ADDR_STROBE_N;
            adv_n_q <= BURST_ADVANCE_N;
        end
    end

    // write enables; all high reads, so reset cannot corrupt a word
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            gw_n_q <= 1'b1;
            mbw_n_q <= 1'b1;
            bw_n_q <= '1;
        end else begin
            gw_n_q <= GLOBAL_WRITE_N; // [RQ2]
            mbw_n_q <= MASTER_BYTE_WRITE_N;
            bw_n_q <= {BYTE_LANE3_WRITE_N, BYTE_LANE2_WRITE_N,
                       BYTE_LANE1_WRITE_N, BYTE_LANE0_WRITE_N};
        end
    end

    // async pins through two flops; idle states mean normal mode
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            oe_n_m <= 1'b1;
            oe_n_s <= 1'b1;
            zz_m <= 1'b0;
            zz_s <= 1'b0;
            mode_m <= 1'b1;
            mode_s <= 1'b1;
            ft_m <= 1'b1;
            ft_s <= 1'b1;
        end else begin
            oe_n_m <= OUTPUT_ENABLE_N;
            oe_n_s <= oe_n_m;
            zz_m <= SNOOZE_REQ;
            zz_s <= zz_m;
            mode_m <= BURST_LINEAR_N;
            mode_s <= mode_m;
            ft_m <= FLOW_THROUGH_SEL_N;
            ft_s <= ft_m;
        end
    end

    // write decode: global wins, then master plus lane enables [RQ3]
    // lane i covers data bits i*8 .. i*8+7 [RQ4]
    always_comb begin
        if (!gw_n_q) begin
            wr_sel = '1;
        end else if (!mbw_n_q) begin
            wr_sel = ~bw_n_q;
        end else begin
            wr_sel = '0;
        end
    end
    assign wr_any = |wr_sel;
    assign zz_hold = zz_s || (wake_q != '0); // [RQ14] [RQ21]

    // cycle decode from the registered strobes and selects
    always_comb begin
        op_d = op_q;
        base_d = base_q;
        cnt_d = cnt_q;
        if (zz_hold) begin
            op_d = sbs_pkg::SBS_DESEL; // [RQ14]
        end else if (!cpu_n_q && !sel1_n_q) begin
            // selects looked at only on a load [RQ6]
            if (!sel2_q || sel2_n_q) begin
                op_d = sbs_pkg::SBS_DESEL; // [RQ7] [RQ20]
            end else begin
                base_d = addr_in_q; // [RQ7]
                cnt_d = `SBS_CNT_ZERO;
                op_d = sbs_pkg::SBS_READ; // write enables ignored [RQ8]
            end
        end else if (!ctrl_n_q) begin
            if (sel1_n_q || !sel2_q || sel2_n_q) begin
                op_d = sbs_pkg::SBS_DESEL; // [RQ9] [RQ20]
            end else begin
                base_d = addr_in_q; // [RQ9]
                cnt_d = `SBS_CNT_ZERO;
                op_d = wr_any ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
            end
        end else if (op_q != sbs_pkg::SBS_DESEL) begin
            // continue or suspend; 2-bit count wraps [RQ10] [RQ19]
            if (!adv_n_q) begin
                cnt_d = cnt_q + `SBS_CNT_ONE;
            end
            // advance high keeps the count [RQ11]
            op_d = wr_any ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
        end
    end

    // burst address; upper bits latched [RQ17] [RQ18]
    assign low_bits = mode_s ? (base_d[1:0] ^ cnt_d)
                             : (base_d[1:0] + cnt_d); // [RQ15]
    assign mem_addr = {base_d[AW-1:2], low_bits};

    // self-timed write of the addressed lanes this cycle [RQ25]
    assign lane_we = (op_d == sbs_pkg::SBS_WRITE) ? wr_sel : '0;

    // cycle kind; idle after reset, and idle takes the continue branch, so a read burst follows
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            op_q <= sbs_pkg::SBS_IDLE;
        end else begin
            op_q <= op_d;
        end
    end

    // latched burst start address, upper bits never advance [RQ19]
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            base_q <= '0;
        end else begin
            base_q <= base_d;
        end
    end

    // two-bit burst count, wraps by its width
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_q <= `SBS_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d; // [RQ10]
        end
    end

    // wake-up timer restarts while snooze is held [RQ21]
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wake_q <= '0;
        end else if (zz_s) begin
            wake_q <= ($clog2(WAKE_CYC+1))'(WAKE_CYC);
        end else if (wake_q != '0) begin
            wake_q <= wake_q - 1'b1;
        end
    end

    // 32768 x 32 array [RQ1]
    sbs_mem #(
        .AW(AW),
        .LANES(LANES),
        .LW(LW)
    ) u_mem (
        .clk(CLK),
        .addr(mem_addr),
        .we(lane_we),
        .wdata(din_q),
        .rdata_q(rd_q),
        .rdata_comb(rd_c)
    );

    // pipelined data comes two cycles after the access [RQ24] [RQ16]
    // flow-through still passes the output flop: a one-cycle shorter path,
    // since every output must leave from a register
    always_comb begin
        dout_d = ft_s ? rd_q : rd_c;
        drive_d = (op_d == sbs_pkg::SBS_READ) && !oe_n_s // [RQ13]
                  && (&bw_n_q) && !zz_hold; // [RQ5] [RQ14]
    end

    // output data register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DQ_OUT <= '0;
        end else begin
            DQ_OUT <= dout_d; // [RQ24]
        end
    end

    // pad enables, all bits equal; off in reset to avoid bus fights
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DQ_OE <= '0;
        end else begin
            DQ_OE <= {(LANES*LW){drive_d}}; // [RQ13]
        end
    end

    // power state flags for the host
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            POWER_DOWN <= 1'b0;
            READY <= 1'b0;
        end else begin
            POWER_DOWN <= zz_hold || (op_d == sbs_pkg::SBS_DESEL); // [RQ20]
            READY <= !zz_hold; // [RQ21]
        end
    end
endmodule

`default_nettype wire

// ==== sbs_chk_assertions.sv ====
/* port checker for the burst sram core.
   assumes the core's top ports; bound at the foot of this file. */
`default_nettype none
module sbs_chk #(
    parameter int LANES = 4,
    parameter int LW = 8
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [LANES*LW-1:0] DQ_OE,
    input wire logic PRIMARY_SELECT_N,
    input wire logic EXPAND_SELECT_LOW_N,
    input wire logic EXPAND_SELECT_HIGH,
    input wire logic CPU_ADDR_STROBE_N,
    input wire logic BYTE_LANE0_WRITE_N,
    input wire logic BYTE_LANE1_WRITE_N,
    input wire logic BYTE_LANE2_WRITE_N,
    input wire logic BYTE_LANE3_WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SNOOZE_REQ,
    input wire logic POWER_DOWN,
    input wire logic READY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic lane_low;
    logic cpu_go;
    // decoded causes; selects only matter on a load
    assign lane_low = !(BYTE_LANE0_WRITE_N && BYTE_LANE1_WRITE_N &&
        BYTE_LANE2_WRITE_N && BYTE_LANE3_WRITE_N);
    assign cpu_go = !CPU_ADDR_STROBE_N && !PRIMARY_SELECT_N && READY;
    a_oe_off: assert property (
        OUTPUT_ENABLE_N [*4] |-> DQ_OE == '0) else $error("pads on");
    a_pad_equal: assert property (
        DQ_OE == '0 || DQ_OE == '1) else $error("pads split");
    a_lane_hiz: assert property (
        lane_low |-> ##[1:3] DQ_OE == '0) else $error("pads on in write");
    a_desel_down: assert property (
        cpu_go && (!EXPAND_SELECT_HIGH || EXPAND_SELECT_LOW_N)
        |-> ##[1:3] POWER_DOWN) else $error("no deselect");
    a_read_wakes: assert property (
        cpu_go && EXPAND_SELECT_HIGH && !EXPAND_SELECT_LOW_N && !SNOOZE_REQ
        |-> ##[1:3] !POWER_DOWN) else $error("read stays down");
    a_pd_hiz: assert property (
        POWER_DOWN [*3] |-> DQ_OE == '0) else $error("pads on while down");
    a_snooze_down: assert property (
        SNOOZE_REQ [*4] |-> POWER_DOWN && !READY) else $error("awake");
    a_wake_ready: assert property (
        $fell(SNOOZE_REQ) |-> !READY ##[1:6] READY) else $error("wake");
    c_read: cover property (cpu_go);
    c_lane: cover property (lane_low);
    c_wake: cover property ($fell(SNOOZE_REQ));
endmodule
bind sbs_core sbs_chk #(.LANES(LANES), .LW(LW)) sbs_chk_inst (
    .CLK(CLK), .ARST_N(ARST_N), .DQ_OE(DQ_OE),
    .PRIMARY_SELECT_N(PRIMARY_SELECT_N),
    .EXPAND_SELECT_LOW_N(EXPAND_SELECT_LOW_N),
    .EXPAND_SELECT_HIGH(EXPAND_SELECT_HIGH),
    .CPU_ADDR_STROBE_N(CPU_ADDR_STROBE_N),
    .BYTE_LANE0_WRITE_N(BYTE_LANE0_WRITE_N),
    .BYTE_LANE1_WRITE_N(BYTE_LANE1_WRITE_N),
    .BYTE_LANE2_WRITE_N(BYTE_LANE2_WRITE_N),
    .BYTE_LANE3_WRITE_N(BYTE_LANE3_WRITE_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .SNOOZE_REQ(SNOOZE_REQ),
    .POWER_DOWN(POWER_DOWN), .READY(READY));
`default_nettype wire

// ==== sbs_host.sv ====
/* host model driving the address, data, strobe, advance, write and high select pins of the sram core.
   assumes one free clock; callers pace one call per edge. */
`default_nettype none
module sbs_host (
    input wire logic clk,
    output logic [14:0] addr,
    output logic [31:0] din,
    output logic sel,
    output logic cpu_addr_strobe_n_n,
    output logic ctrl_addr_strobe_n_n,
    output logic adv_n,
    output logic [5:0] wr_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet pins at time zero
    initial begin
        {addr, din, sel} = '0;
        {cpu_addr_strobe_n_n, ctrl_addr_strobe_n_n, adv_n, wr_n} = '1;
    end
    // load on one strobe; wr_n is global, master, then lanes 3..0
    task go(input logic cpu, input logic s, input logic [14:0] a,
            input logic [31:0] d, input logic [5:0] w);
        @(posedge clk);
        cpu_addr_strobe_n_n <= !cpu;
        ctrl_addr_strobe_n_n <= cpu;
        sel <= s;
        addr <= a;
        din <= d;
        wr_n <= w;
        adv_n <= 1'h1;
    endtask
    // released data is inverted so a stale value never passes
    task step(input logic burst_advance_n);
        @(posedge clk);
        {cpu_addr_strobe_n_n, ctrl_addr_strobe_n_n} <= 2'h3;
        adv_n <= burst_advance_n;
        wr_n <= 6'h3F;
        din <= ~din;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/* self-checking bench for the burst sram core.
   assumes the host model and the bound checker; 10 MHz clock. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [14:0] BASE = 15'h1230;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic oe_n = 1'h1;
    logic zz = 1'h0;
    logic mode_n = 1'h1;
    logic ft_n = 1'h1;
    logic sel1_n = 1'h0;
    logic sel2_n = 1'h0;
    logic [14:0] addr;
    logic [31:0] din, dout, doe;
    logic sel, cpu_addr_strobe_n_n, ctrl_addr_strobe_n_n, adv_n, pd, rdy;
    logic [5:0] wr_n;
    logic [31:0] ref_q [4];
    int failures = 0;
    int cmp_count = 0;
    sbs_host sbs_host_inst (.clk(clk), .addr(addr), .din(din), .sel(sel),
        .cpu_addr_strobe_n_n(cpu_addr_strobe_n_n), .ctrl_addr_strobe_n_n(ctrl_addr_strobe_n_n), .adv_n(adv_n), .wr_n(wr_n));
    sbs_core sbs_core_inst (.CLK(clk), .ARST_N(arst_n), .ADDR(addr),
        .DQ_IN(din), .DQ_OUT(dout), .DQ_OE(doe), .PRIMARY_SELECT_N(sel1_n),
        .EXPAND_SELECT_LOW_N(sel2_n), .EXPAND_SELECT_HIGH(sel),
        .CPU_ADDR_STROBE_N(cpu_addr_strobe_n_n), .CTRL_ADDR_STROBE_N(ctrl_addr_strobe_n_n),
        .BURST_ADVANCE_N(adv_n), .GLOBAL_WRITE_N(wr_n[5]),
        .MASTER_BYTE_WRITE_N(wr_n[4]), .BYTE_LANE0_WRITE_N(wr_n[0]),
        .BYTE_LANE1_WRITE_N(wr_n[1]), .BYTE_LANE2_WRITE_N(wr_n[2]),
        .BYTE_LANE3_WRITE_N(wr_n[3]), .OUTPUT_ENABLE_N(oe_n),
        .SNOOZE_REQ(zz), .BURST_LINEAR_N(mode_n),
        .FLOW_THROUGH_SEL_N(ft_n), .POWER_DOWN(pd), .READY(rdy));
    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task conclude();
        $display("compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded wait on ready (r=1) or power down (r=0)
    task wt(input logic r, input logic v);
        repeat (20) begin
            @(posedge clk);
            #10;
            if ((r ? rdy : pd) === v) break;
        end
        chk("status", {31'h0, r ? rdy : pd}, {31'h0, v});
    endtask
    // read burst; beat k settles lat edges after its load edge
    task rd(input logic [14:0] a, input int n, input int lat,
            input logic oe);
        logic [1:0] x;
        sbs_host_inst.go(1'h1, 1'h1, a, 32'h0, 6'h3F);
        for (int i = 1; i < n + lat; i++) begin
            sbs_host_inst.step(i >= n);
            #10;
            x = mode_n ? a[1:0] ^ 2'(i - lat) : a[1:0] + 2'(i - lat);
            if (i >= lat && oe) chk("dout", dout, ref_q[x]);
            if (i >= lat) chk("dq_oe", doe, {32{oe}});
        end
        sbs_host_inst.step(1'h1);
    endtask
    // watchdog well beyond the ~75 cycle run
    initial begin
        #200000;
        failures++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        wt(1'h1, 1'h1);
        // whole-word writes through the controller strobe
        for (int i = 0; i < 4; i++) begin
            ref_q[i] = 32'h5A00C300 + i;
            sbs_host_inst.go(1'h0, 1'h1, BASE + 15'(i), ref_q[i], 6'h1F);
        end
        sbs_host_inst.step(1'h1);
        oe_n <= 1'h0;
        repeat (3) sbs_host_inst.step(1'h1);
        rd(BASE + 15'h1, 5, 3, 1'h1);
        // one lane only; output enable parked high around the write
        oe_n <= 1'h1;
        sbs_host_inst.go(1'h0, 1'h1, BASE + 15'h2, 32'hA5A5A5A5, 6'h2E);
        ref_q[2][7:0] = 8'hA5;
        sbs_host_inst.step(1'h1);
        oe_n <= 1'h0;
        mode_n <= 1'h0;
        repeat (4) sbs_host_inst.step(1'h1);
        rd(BASE + 15'h3, 5, 3, 1'h1);
        ft_n <= 1'h0;
        repeat (4) sbs_host_inst.step(1'h1);
        rd(BASE, 2, 2, 1'h1);
        {ft_n, mode_n, oe_n} <= 3'h7;
        sbs_host_inst.go(1'h1, 1'h0, BASE, 32'h0, 6'h3F);
        wt(1'h0, 1'h1);
        rd(BASE, 2, 3, 1'h0);
        zz <= 1'h1;
        wt(1'h1, 1'h0);
        chk("power_down", {31'h0, pd}, 32'h1);
        @(posedge clk);
        zz <= 1'h0;
        wt(1'h1, 1'h1);
        // cpu strobe with primary select high is ignored: stays down
        @(posedge clk);
        sel1_n <= 1'h1;
        sbs_host_inst.go(1'h1, 1'h1, BASE, 32'h0, 6'h3F);
        repeat (3) sbs_host_inst.step(1'h1);
        #10;
        chk("ignored_strobe", {31'h0, pd}, 32'h1);
        sel1_n <= 1'h0;
        sbs_host_inst.go(1'h1, 1'h1, BASE, 32'h0, 6'h3F);
        wt(1'h0, 1'h0);
        conclude();
    end
endmodule
`default_nettype wire
